//--- lmfc_pkg.sv
// Purpose: constants and types for the multiframe-clock sync status and link check block
// Assumes: one device clock, registers reached through the serial control port engine
// Notes:   offsets are byte addresses of the 8-bit control port
// Operation
// - ch1 flags follow live state; latch-enable latches rising edge, pulls irq, w1c.
// - status bit 3 reports ch1 multiframe alignment locked.
// - status bit 2 reports ch1 multiframe alignment rotated.
// - status bit 1 reports ch1 sampled phase outside error window.
// - status bit 0 reports ch1 multiframe alignment tripped.
// - check bit 5 set when multiframe delay exceeds frames per multiframe.
// - check bit 4 set when window limit is unsupported.
// - check bit 3 set when converter, lane, sample, octet combination unsupported.
// - check bit 2 set when frames per multiframe not 16 or 32.
// - check bit 1 set when subclass is neither 0 nor 1.
// - check bit 0 set when interpolation not 1, 2, 4 or 8.
// - two-bit window gives +/- tolerance; errors inside cause no adjustment.
// - each adjustment captures four-bit two's complement phase error, low nibble.
// - upper last-error bit 7 set when error fell below lower boundary.
// - upper last-error bit 6 set when error fell above upper boundary.
// - rising edge of clear-last strobe clears captured error and both flags.
// - rising edge of sticky-clear strobe clears rotated and tripped flags.
package lmfc_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CH1_IRQ_FLAGS = 12'h026;
   localparam logic [11:0] ADDR_CFG_CHECKS    = 12'h030;
   localparam logic [11:0] ADDR_ERR_WINDOW    = 12'h034;
   localparam logic [11:0] ADDR_LAST_ERR_LOW  = 12'h038;
   localparam logic [11:0] ADDR_LAST_ERR_HIGH = 12'h039;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_LOCKED   = 3;
   localparam int BIT_ROTATED  = 2;
   localparam int BIT_WINDOW   = 1;
   localparam int BIT_TRIPPED  = 0;
   localparam int BIT_DLYOVER  = 5;
   localparam int BIT_WINLIM   = 4;
   localparam int BIT_LINKMODE = 3;
   localparam int BIT_KBAD     = 2;
   localparam int BIT_SUBCLASS = 1;
   localparam int BIT_INTERP   = 0;
   localparam int BIT_UNDER    = 7;
   localparam int BIT_OVER     = 6;
   localparam logic [1:0] WINDOW_RESET      = 2'h0;
   localparam logic [3:0] LAST_ERR_RESET    = 4'h0;
   localparam logic [7:0] RDATA_RESET       = 8'h00;
   // window value the alignment logic cannot use
   localparam logic [1:0] WINDOW_UNSUPPORTED = 2'h3;
   localparam logic [5:0] K_SIXTEEN         = 6'h10;
   localparam logic [5:0] K_THIRTYTWO       = 6'h20;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [5:0] multiframe_delay_setting;
      logic [5:0] frames_per_multiframe_setting;
      logic [2:0] subclass;
      logic [3:0] interp_factor;
      logic [3:0] conv_count;
      logic [3:0] lane_count;
      logic [3:0] samples_per_frame;
      logic [3:0] octets_per_frame;
   } lmfc_cfg_t;

   // bit order matches the status register: locked, rotated, window, tripped
   typedef struct packed {
      logic locked;
      logic rotated;
      logic window;
      logic tripped;
   } lmfc_align_t;
endpackage

//--- lmfc_flag.sv
// Purpose: one status flag, live or latching with write-one-to-clear
// Assumes: inputs come from logic on the device clock
// Notes:   a set in the cycle of a clear wins
`timescale 1ns/1ps
`default_nettype none
module lmfc_flag (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic live_i,
   input  wire logic latch_en_i,
   input  wire logic clear_i,
   output logic      flag_o,
   output logic      irq_o
);
   logic prev_reg;
   logic flag_reg;
   logic flag_next;

   always_comb begin
      if (!latch_en_i) begin
         flag_next = live_i;
      end else if (live_i && !prev_reg) begin
         flag_next = 1'b1;
      end else if (clear_i) begin
         flag_next = 1'b0;
      end else begin
         flag_next = flag_reg;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         prev_reg <= live_i;
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;
   assign irq_o  = flag_reg & latch_en_i;
endmodule // lmfc_flag
`default_nettype wire

//--- lmfc_sync_status.sv
// Purpose: ch1 alignment status flags, link legality checks, phase error window and last-error record
// Assumes: register port driven by the serial control port engine on the device clock
// Notes:   read data registered one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module lmfc_sync_status
   import lmfc_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        RESETN_I,
   input  wire logic [11:0] ADDR_I,
   input  wire logic        WR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        RD_I,
   output logic      [7:0]  RDATA_O,
   input  wire lmfc_align_t ALIGN_LIVE_I,
   input  wire lmfc_align_t ALIGN_LATCH_EN_I,
   input  wire lmfc_cfg_t   CFG_I,
   input  wire logic        PHASE_VALID_I,
   input  wire logic [3:0]  PHASE_ERR_I,
   input  wire logic        CLEAR_CAPTURED_ERROR_STROBE_I,
   input  wire logic        CLEAR_STICKY_STATUS_STROBE_I,
   output logic             PHASE_ADJUST_O,
   output logic      [1:0]  PHASE_TOLERANCE_O,
   output logic      [7:0]  CFG_CHECKS_O,
   output logic             IRQ_N_O
);
   // ----------------------------------------------------------------
   // strobe edges
   // ----------------------------------------------------------------
   logic clr_last_prev_reg;
   logic clr_sticky_prev_reg;
   logic clr_last_rise;
   logic clr_sticky_rise;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         clr_last_prev_reg   <= 1'b0;
         clr_sticky_prev_reg <= 1'b0;
      end else begin
         clr_last_prev_reg   <= CLEAR_CAPTURED_ERROR_STROBE_I;
         clr_sticky_prev_reg <= CLEAR_STICKY_STATUS_STROBE_I;
      end
   end

   assign clr_last_rise   = CLEAR_CAPTURED_ERROR_STROBE_I & ~clr_last_prev_reg;
   assign clr_sticky_rise = CLEAR_STICKY_STATUS_STROBE_I & ~clr_sticky_prev_reg;

   // ----------------------------------------------------------------
   // ch1 alignment status flags
   // ----------------------------------------------------------------
   logic        flag_wr;
   logic [3:0]  flag_clear;
   logic [3:0]  flag_val;
   logic [3:0]  flag_irq;
   logic [3:0]  live_vec;
   logic [3:0]  latch_vec;

   assign flag_wr   = WR_I && (ADDR_I == ADDR_CH1_IRQ_FLAGS);
   assign live_vec  = ALIGN_LIVE_I;
   assign latch_vec = ALIGN_LATCH_EN_I;

   always_comb begin
      flag_clear = {4{flag_wr}} & WDATA_I[3:0];
      flag_clear[BIT_ROTATED] = flag_clear[BIT_ROTATED] | clr_sticky_rise;
      flag_clear[BIT_TRIPPED] = flag_clear[BIT_TRIPPED] | clr_sticky_rise;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         lmfc_flag lmfc_flag_inst (
            .clk_i      (CLK_I),
            .resetn_i   (RESETN_I),
            .live_i     (live_vec[gi]),
            .latch_en_i (latch_vec[gi]),
            .clear_i    (flag_clear[gi]),
            .flag_o     (flag_val[gi]),
            .irq_o      (flag_irq[gi])
         );
      end
   endgenerate

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         IRQ_N_O <= 1'b1;
      end else begin
         IRQ_N_O <= ~(|flag_irq);
      end
   end

   // ----------------------------------------------------------------
   // link legality checks
   // ----------------------------------------------------------------
   logic [7:0] checks;
   logic       mode_ok;

   // supported modes: one or two converters, one, two, four or eight lanes, one or two samples, one, two or four octets
   always_comb begin
      mode_ok = (CFG_I.conv_count == 4'h1 || CFG_I.conv_count == 4'h2) &&
                (CFG_I.lane_count == 4'h1 || CFG_I.lane_count == 4'h2 ||
                 CFG_I.lane_count == 4'h4 || CFG_I.lane_count == 4'h8) &&
                (CFG_I.samples_per_frame == 4'h1 || CFG_I.samples_per_frame == 4'h2) &&
                (CFG_I.octets_per_frame == 4'h1 || CFG_I.octets_per_frame == 4'h2 ||
                 CFG_I.octets_per_frame == 4'h4);
   end

   logic [1:0] window_reg;

   always_comb begin
      checks = 8'h00;
      checks[BIT_DLYOVER]  = CFG_I.multiframe_delay_setting >
                             CFG_I.frames_per_multiframe_setting;
      checks[BIT_WINLIM]   = (window_reg == WINDOW_UNSUPPORTED);
      checks[BIT_LINKMODE] = ~mode_ok;
      checks[BIT_KBAD]     = (CFG_I.frames_per_multiframe_setting != K_SIXTEEN) &&
                             (CFG_I.frames_per_multiframe_setting != K_THIRTYTWO);
      checks[BIT_SUBCLASS] = (CFG_I.subclass > 3'h1);
      checks[BIT_INTERP]   = !(CFG_I.interp_factor == 4'h1 || CFG_I.interp_factor == 4'h2 ||
                               CFG_I.interp_factor == 4'h4 || CFG_I.interp_factor == 4'h8);
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         CFG_CHECKS_O <= 8'h00;
      end else begin
         CFG_CHECKS_O <= checks;
      end
   end

   // ----------------------------------------------------------------
   // error window register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         window_reg <= WINDOW_RESET;
      end else if (WR_I && ADDR_I == ADDR_ERR_WINDOW) begin
         window_reg <= WDATA_I[1:0];
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PHASE_TOLERANCE_O <= WINDOW_RESET;
      end else begin
         PHASE_TOLERANCE_O <= window_reg;
      end
   end

   // ----------------------------------------------------------------
   // phase compare, adjustment and last-error capture
   // ----------------------------------------------------------------
   logic signed [3:0] err_s;
   logic signed [3:0] tol_s;
   logic              under;
   logic              over;
   logic              adjust;
   logic [3:0]        last_err_reg;
   logic              under_reg;
   logic              over_reg;

   assign err_s  = PHASE_ERR_I;
   assign tol_s  = {2'b00, window_reg};
   assign under  = err_s < -tol_s;
   assign over   = err_s > tol_s;
   assign adjust = PHASE_VALID_I && (under || over);

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         PHASE_ADJUST_O <= 1'b0;
      end else begin
         PHASE_ADJUST_O <= adjust;
      end
   end

   // a capture in the cycle of a clear wins
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         last_err_reg <= LAST_ERR_RESET;
         under_reg    <= 1'b0;
         over_reg     <= 1'b0;
      end else if (adjust) begin
         last_err_reg <= PHASE_ERR_I;
         under_reg    <= under;
         over_reg     <= over;
      end else if (clr_last_rise) begin
         last_err_reg <= LAST_ERR_RESET;
         under_reg    <= 1'b0;
         over_reg     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      rd_mux = 8'h00;
      if (ADDR_I == ADDR_CH1_IRQ_FLAGS) begin
         rd_mux[3:0] = flag_val;
      end else if (ADDR_I == ADDR_CFG_CHECKS) begin
         rd_mux = checks;
      end else if (ADDR_I == ADDR_ERR_WINDOW) begin
         rd_mux[1:0] = window_reg;
      end else if (ADDR_I == ADDR_LAST_ERR_LOW) begin
         rd_mux[3:0] = last_err_reg;
      end else if (ADDR_I == ADDR_LAST_ERR_HIGH) begin
         rd_mux[BIT_UNDER] = under_reg;
         rd_mux[BIT_OVER]  = over_reg;
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RDATA_O <= RDATA_RESET;
      end else if (RD_I) begin
         RDATA_O <= rd_mux;
      end
   end
endmodule // lmfc_sync_status
`default_nettype wire

//--- lmfc_sync_status_sva.sv
// Purpose: concurrent checks on the sync status and link check block
// Assumes: one device clock, asynchronous active-low reset
// Notes:   bound to every lmfc_sync_status
`timescale 1ns/1ps
`default_nettype none
module lmfc_sync_status_sva
   import lmfc_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        RESETN_I,
   input wire logic [11:0] ADDR_I,
   input wire logic        WR_I,
   input wire logic [7:0]  WDATA_I,
   input wire logic        RD_I,
   input wire logic [7:0]  RDATA_O,
   input wire lmfc_align_t ALIGN_LIVE_I,
   input wire lmfc_align_t ALIGN_LATCH_EN_I,
   input wire lmfc_cfg_t   CFG_I,
   input wire logic        PHASE_VALID_I,
   input wire logic [3:0]  PHASE_ERR_I,
   input wire logic        PHASE_ADJUST_O,
   input wire logic [1:0]  PHASE_TOLERANCE_O,
   input wire logic [7:0]  CFG_CHECKS_O,
   input wire logic        IRQ_N_O
);
   // ----------------------------------------------------------------
   // expected checks and window decision
   // ----------------------------------------------------------------
   logic              mode_bad;
   logic [7:0]        exp_chk;
   logic [1:0]        wdata_lo;
   logic signed [4:0] err_s;
   logic signed [4:0] tol_s;
   logic              outside;
   assign mode_bad = !(CFG_I.conv_count inside {4'h1, 4'h2}) || !(CFG_I.lane_count inside {4'h1, 4'h2, 4'h4, 4'h8})
                  || !(CFG_I.samples_per_frame inside {4'h1, 4'h2}) || !(CFG_I.octets_per_frame inside {4'h1, 4'h2, 4'h4});
   // window bit left out: it follows the window register, not CFG_I
   assign exp_chk  = {2'h0, CFG_I.multiframe_delay_setting > CFG_I.frames_per_multiframe_setting, 1'b0, mode_bad,
                      !(CFG_I.frames_per_multiframe_setting inside {K_SIXTEEN, K_THIRTYTWO}),
                      CFG_I.subclass > 3'h1, !(CFG_I.interp_factor inside {4'h1, 4'h2, 4'h4, 4'h8})};
   assign wdata_lo = WDATA_I[1:0];
   assign err_s    = {PHASE_ERR_I[3], PHASE_ERR_I};
   assign tol_s    = {3'h0, PHASE_TOLERANCE_O};
   assign outside  = (err_s < -tol_s) || (err_s > tol_s);

   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_chk;
      1'b1 |=> (CFG_CHECKS_O & 8'hef) == $past(exp_chk);
   endproperty
   a_chk: assert property (p_chk) else $error("link check bits wrong");
   property p_tol;
      (WR_I && ADDR_I == ADDR_ERR_WINDOW) |=> ##1 PHASE_TOLERANCE_O == $past(wdata_lo, 2);
   endproperty
   a_tol: assert property (p_tol) else $error("tolerance not taken from write");
   property p_adj;
      // tolerance port lags the window register by one cycle: skip samples right after a window write
      PHASE_VALID_I && !$past(WR_I && ADDR_I == ADDR_ERR_WINDOW) |=> PHASE_ADJUST_O == $past(outside);
   endproperty
   a_adj: assert property (p_adj) else $error("adjust decision wrong");
   property p_adj_only;
      !PHASE_VALID_I |=> !PHASE_ADJUST_O;
   endproperty
   a_adj_only: assert property (p_adj_only) else $error("adjust without sample");
   property p_irq_set;
      ((ALIGN_LIVE_I & ~$past(ALIGN_LIVE_I) & ALIGN_LATCH_EN_I) != 4'h0) ##1 $stable(ALIGN_LATCH_EN_I) |=> !IRQ_N_O;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("latched edge gave no interrupt");
   property p_irq_off;
      $past(ALIGN_LATCH_EN_I) == 4'h0 |-> IRQ_N_O;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt with latching off");
   property p_rd_win;
      (RD_I && !WR_I && ADDR_I == ADDR_ERR_WINDOW) |=> RDATA_O == {6'h00, PHASE_TOLERANCE_O};
   endproperty
   a_rd_win: assert property (p_rd_win) else $error("window readback wrong");
   property p_rd_hi;
      (RD_I && ADDR_I == ADDR_LAST_ERR_HIGH) |=> RDATA_O[5:0] == 6'h00;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("reserved error bits set");
   c_adj: cover property (PHASE_ADJUST_O);
   c_irq: cover property (!IRQ_N_O);
   c_chk: cover property (CFG_CHECKS_O != 8'h00);
endmodule // lmfc_sync_status_sva
bind lmfc_sync_status lmfc_sync_status_sva lmfc_sync_status_sva_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ALIGN_LIVE_I(ALIGN_LIVE_I),
   .ALIGN_LATCH_EN_I(ALIGN_LATCH_EN_I), .CFG_I(CFG_I), .PHASE_VALID_I(PHASE_VALID_I), .PHASE_ERR_I(PHASE_ERR_I),
   .PHASE_ADJUST_O(PHASE_ADJUST_O), .PHASE_TOLERANCE_O(PHASE_TOLERANCE_O), .CFG_CHECKS_O(CFG_CHECKS_O),
   .IRQ_N_O(IRQ_N_O));
`default_nettype wire

//--- lmfc_sync_status_bench.sv
// Purpose: self-checking bench for the sync status and link check block
// Assumes: inputs driven on the falling edge
// Notes:   register port driven with one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module lmfc_sync_status_bench;
   import lmfc_pkg::*;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [11:0] addr = 12'h000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   lmfc_align_t live = 4'h0;
   lmfc_align_t en = 4'h0;
   lmfc_cfg_t   good = '{6'h00, 6'h10, 3'h1, 4'h1, 4'h2, 4'h4, 4'h1, 4'h1};
   lmfc_cfg_t   cfg = '{6'h00, 6'h10, 3'h1, 4'h1, 4'h2, 4'h4, 4'h1, 4'h1};
   lmfc_cfg_t   c;
   logic [11:0] reset_addrs [6] = '{ADDR_CFG_CHECKS, ADDR_ERR_WINDOW, ADDR_LAST_ERR_LOW, ADDR_LAST_ERR_HIGH,
                                    ADDR_CH1_IRQ_FLAGS, 12'h031};
   logic        vld = 1'b0;
   logic [3:0]  perr = 4'h0;
   logic        clr_err = 1'b0;
   logic        clr_sticky = 1'b0;
   logic        adj;
   logic [1:0]  tol;
   logic [7:0]  chk_o;
   logic        irq_n;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cyc = 0;

   lmfc_sync_status lmfc_sync_status_inst (.CLK_I(clk), .RESETN_I(resetn), .ADDR_I(addr), .WR_I(wr),
      .WDATA_I(wdata), .RD_I(rd), .RDATA_O(rdata), .ALIGN_LIVE_I(live), .ALIGN_LATCH_EN_I(en), .CFG_I(cfg),
      .PHASE_VALID_I(vld), .PHASE_ERR_I(perr), .CLEAR_CAPTURED_ERROR_STROBE_I(clr_err),
      .CLEAR_STICKY_STATUS_STROBE_I(clr_sticky), .PHASE_ADJUST_O(adj), .PHASE_TOLERANCE_O(tol),
      .CFG_CHECKS_O(chk_o), .IRQ_N_O(irq_n));

   always #5 clk = ~clk;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task results;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk); addr = a; wdata = d; wr = 1'b1;
      @(negedge clk); wr = 1'b0;
   endtask
   task rd_reg(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk); addr = a; rd = 1'b1;
      @(negedge clk); rd = 1'b0;
      check(rdata, e);
   endtask
   task phase(input logic [3:0] e, input logic a);
      @(negedge clk); perr = e; vld = 1'b1;
      @(negedge clk); vld = 1'b0;
      check({7'h0, adj}, {7'h0, a});
   endtask
   task cfg_try(input lmfc_cfg_t k, input logic [7:0] e);
      @(negedge clk); cfg = k;
      rd_reg(ADDR_CFG_CHECKS, e);
      check(chk_o, e);
   endtask
   // one-cycle high pulse on the sticky-clear strobe or on the clear-last strobe
   task pulse(input logic sticky);
      @(negedge clk);
      if (sticky) clr_sticky = 1'b1;
      else clr_err = 1'b1;
      @(negedge clk);
      clr_sticky = 1'b0;
      clr_err = 1'b0;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         $display("mismatch at %0t: timeout", $time);
         results();
      end
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      foreach (reset_addrs[i])
         rd_reg(reset_addrs[i], 8'h00);
      wr_reg(ADDR_CFG_CHECKS, 8'hff);
      rd_reg(ADDR_CFG_CHECKS, 8'h00);
      $display("test reset done");
      c = good; c.multiframe_delay_setting = 6'h11; cfg_try(c, 8'h20);
      c = good; c.frames_per_multiframe_setting = 6'h14; cfg_try(c, 8'h04);
      c.frames_per_multiframe_setting = 6'h20; c.multiframe_delay_setting = 6'h11; cfg_try(c, 8'h00);
      c = good; c.subclass = 3'h2; cfg_try(c, 8'h02);
      c = good; c.interp_factor = 4'h3; cfg_try(c, 8'h01);
      c.interp_factor = 4'h8; cfg_try(c, 8'h00);
      c = good; c.conv_count = 4'h3; cfg_try(c, 8'h08);
      c = good; c.lane_count = 4'h3; cfg_try(c, 8'h08);
      wr_reg(ADDR_ERR_WINDOW, 8'h03);
      cfg_try(good, 8'h10);
      wr_reg(ADDR_ERR_WINDOW, 8'h00);
      cfg_try(good, 8'h00);
      $display("test checks done");
      phase(4'h1, 1'b1);
      wr_reg(ADDR_ERR_WINDOW, 8'hfe);
      rd_reg(ADDR_ERR_WINDOW, 8'h02);
      check({6'h0, tol}, 8'h02);
      phase(4'h2, 1'b0);
      phase(4'he, 1'b0);
      phase(4'hd, 1'b1);
      rd_reg(ADDR_LAST_ERR_LOW, 8'h0d);
      rd_reg(ADDR_LAST_ERR_HIGH, 8'h80);
      phase(4'h3, 1'b1);
      phase(4'h1, 1'b0);
      rd_reg(ADDR_LAST_ERR_LOW, 8'h03);
      rd_reg(ADDR_LAST_ERR_HIGH, 8'h40);
      pulse(1'b0);
      rd_reg(ADDR_LAST_ERR_LOW, 8'h00);
      rd_reg(ADDR_LAST_ERR_HIGH, 8'h00);
      $display("test phase done");
      @(negedge clk); live = 4'hf;
      repeat (2) @(negedge clk);
      rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h0f);
      wr_reg(ADDR_CH1_IRQ_FLAGS, 8'h0f);
      rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h0f);
      check({7'h0, irq_n}, 8'h01);
      live = 4'h0;
      rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h00);
      en = 4'hf;
      for (int b = 0; b < 4; b++) begin
         @(negedge clk); live = lmfc_align_t'(4'h1 << b);
         @(negedge clk); live = 4'h0;
         repeat (2) @(negedge clk);
         check({7'h0, irq_n}, 8'h00);
         rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h01 << b);
         wr_reg(ADDR_CH1_IRQ_FLAGS, 8'h01 << b);
         repeat (2) @(negedge clk);
         check({7'h0, irq_n}, 8'h01);
         rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h00);
      end
      @(negedge clk); live = 4'hf;
      @(negedge clk); live = 4'h0;
      pulse(1'b1);
      rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h0a);
      wr_reg(ADDR_CH1_IRQ_FLAGS, 8'hfa);
      rd_reg(ADDR_CH1_IRQ_FLAGS, 8'h00);
      $display("test flags done");
      results();
   end
endmodule // lmfc_sync_status_bench
`default_nettype wire
